// ---- hdl/ufo_pkg.sv ----
// package of register map, fields and timing for the uart frame option block
package ufo_pkg;
	// register byte addresses (word aligned)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_DATA = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;
	localparam logic [3:0] ADDR_CLR = 4'hc;
	// control register fields
	localparam int C_PERIPH = 0;
	localparam int C_TXEN = 1;
	localparam int C_RXEN = 2;
	localparam int C_WLEN9 = 3;
	localparam int C_PAREN = 4;
	localparam int C_PARSEL = 5;
	localparam int C_PARIE = 6;
	localparam int C_LIN = 7;
	localparam int C_BRKLEN = 8;
	localparam int C_BRKIE = 9;
	localparam int C_SYNC = 10;
	localparam int C_LAST_BIT_CLOCK_PULSE = 11;
	localparam int C_CLOCK_POLARITY = 12;
	localparam int C_CLOCK_PHASE = 13;
	localparam int C_HDX = 14;
	localparam int C_SBK = 15;
	localparam int CTRL_W = 16;
	localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
	// status register fields
	localparam int S_PERR = 0;
	localparam int S_BRK = 1;
	localparam int S_RXNE = 2;
	localparam int S_TXBUSY = 3;
	localparam int S_FERR = 4;
	localparam int S_IRQ = 5;
	// clear register fields, write one to clear
	localparam int K_PERR = 0;
	localparam int K_BRK = 1;
	localparam int K_FERR = 4;
	// timing
	localparam int OVS = 16;
	localparam int BAUD_DIV_RST = 16;
	localparam int BRK_TX_BITS = 13;
	localparam int BRK_TX_STOP = 2;
	localparam int BRK_RX_SHORT = 10;
	localparam int BRK_RX_LONG = 11;
	localparam int MAJ_A = 7;
	localparam int MAJ_B = 8;
	localparam int MAJ_C = 9;
	// transmit states
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_STOP = 3'b011,
		TX_BRK = 3'b100,
		TX_BRKSTOP = 3'b101
	} ufo_tx_t;
	// receive states
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_DATA = 2'b01,
		RX_STOP = 2'b10,
		RX_HALT = 2'b11
	} ufo_rx_t;
	// break detector states
	typedef enum logic [1:0] {
		BD_SEEK = 2'b00,
		BD_COUNT = 2'b01,
		BD_DELIM = 2'b10
	} ufo_bd_t;
endpackage : ufo_pkg

// ---- hdl/ufo_frame.sv ----
// uart frame options: parity, lin break, synchronous clock and half duplex
`timescale 1ns/100ps
module ufo_frame
	import ufo_pkg::*;
#(
	parameter int DIV_W = 16
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rx_pin,
	output logic tx_out,
	output logic tx_oe,
	output logic sync_clk,
	output logic irq
);
	// software visible state
	logic [CTRL_W-1:0] ctrl; // control bits
	logic [DIV_W-1:0] baud_div; // mclk cycles per oversample tick
	logic [8:0] tx_word; // word written for sending
	logic tx_pend; // written word waiting for the shifter
	logic [8:0] rx_word; // last received word
	logic rxne; // received word present
	logic parity_error_flag; // sticky parity error
	logic break_detected_flag; // sticky break flag
	logic ferr; // sticky framing error
	logic ack; // bus answer phase
	ufo_tx_t tx_st; // transmit state, also read back as busy status
	logic tx_sbk_take; // break request accepted by an idle shifter
	// control aliases
	wire logic peripheral_en = ctrl[C_PERIPH];
	wire logic transmitter_en = ctrl[C_TXEN];
	wire logic receiver_en = ctrl[C_RXEN];
	wire logic wlen9 = ctrl[C_WLEN9];
	wire logic parity_enable = ctrl[C_PAREN];
	wire logic parity_select = ctrl[C_PARSEL];
	wire logic lin_mode_en = ctrl[C_LIN];
	wire logic break_len_sel = ctrl[C_BRKLEN];
	wire logic sync_clock_en = ctrl[C_SYNC];
	wire logic last_bit_clock_pulse = ctrl[C_LAST_BIT_CLOCK_PULSE];
	wire logic clock_polarity = ctrl[C_CLOCK_POLARITY];
	wire logic clock_phase = ctrl[C_CLOCK_PHASE];
	wire logic half_duplex_sel = ctrl[C_HDX];
	// data bits per frame including parity: 8 or 9
	wire logic [3:0] nbits = wlen9 ? 4'h9 : 4'h8;
	// bus strobes, taken on the second cycle so waitrequest drops once
	wire logic wr = avs_write && ack;
	wire logic rd = avs_read && ack;
	wire logic wr_data = wr && avs_address == ADDR_DATA;
	wire logic wr_clr = wr && avs_address == ADDR_CLR;
	// one wait cycle per access, then the answer
	// waitrequest is registered beside ack so the port comes straight from a flop
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			ack <= 1'b0;
			avs_waitrequest <= 1'b1;
		end
		else
		begin
			ack <= (avs_read || avs_write) && !ack;
			avs_waitrequest <= !((avs_read || avs_write) && !ack);
		end
	end
	// control and divider registers; unmapped writes ignored
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			ctrl <= CTRL_RST;
			baud_div <= DIV_W'(BAUD_DIV_RST);
		end
		else if (wr && avs_address == ADDR_CTRL)
		begin
			ctrl <= avs_writedata[CTRL_W-1:0];
			baud_div <= avs_writedata[CTRL_W+:DIV_W];
		end
		else if (tx_sbk_take)
			ctrl[C_SBK] <= 1'b0; // break request self clears once taken
	end
	// read mux, registered; unmapped reads return zero
	always_ff @(posedge mclk)
	begin
		if (reset)
			avs_readdata <= 32'h0;
		else if (avs_read && !ack)
		begin
			if (avs_address == ADDR_CTRL)
				avs_readdata <= {baud_div, ctrl};
			else if (avs_address == ADDR_DATA)
				avs_readdata <= {23'h0, rx_word};
			else if (avs_address == ADDR_STAT)
				avs_readdata <= {26'h0, irq, ferr, tx_pend || tx_st != TX_IDLE, rxne,
					break_detected_flag, parity_error_flag};
			else
				avs_readdata <= 32'h0;
		end
	end
	// oversample tick divider
	logic [DIV_W-1:0] div_cnt; // counts down to the tick
	logic tick; // one cycle pulse per oversample
	always_ff @(posedge mclk)
	begin
		if (reset || !peripheral_en)
		begin
			div_cnt <= '0;
			tick <= 1'b0;
		end
		else if (div_cnt == '0)
		begin
			div_cnt <= baud_div - DIV_W'(1);
			tick <= 1'b1;
		end
		else
		begin
			div_cnt <= div_cnt - DIV_W'(1);
			tick <= 1'b0;
		end
	end
	// receive pin synchroniser; a change counts once stages one and two agree
	logic [2:0] rx_sync; // stage 0 only feeds stage 1
	logic rx_line; // filtered line level
	logic tx_line; // our own driven level for the internal loop
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			rx_sync <= 3'b111;
			rx_line <= 1'b1;
		end
		else
		begin
			rx_sync <= {rx_sync[1:0], rx_pin};
			if (rx_sync[1] == rx_sync[2])
				rx_line <= rx_sync[2];
		end
	end
	// half duplex reads the shared wire, which includes our own drive
	wire logic rx_in = half_duplex_sel ? (rx_line && tx_line) : rx_line;
	// parity of the low seven or eight data bits, odd when select is set
	function automatic logic par_of(input logic [8:0] w, input logic l9, input logic ps);
		logic p;
		p = l9 ? ^w[7:0] : ^w[6:0];
		return p ^ ps;
	endfunction : par_of
	// transmitter
	logic [3:0] tx_os; // oversample count within a bit
	logic [3:0] tx_bit; // bit index
	logic [8:0] tx_sh; // shift register
	wire logic tx_bit_end = tick && tx_os == 4'(OVS - 1);
	// frames and breaks start on a tick so the first bit is a full sixteen ticks long
	assign tx_sbk_take = tick && tx_st == TX_IDLE && ctrl[C_SBK] && lin_mode_en
		&& transmitter_en;
	always_ff @(posedge mclk)
	begin
		if (reset || !peripheral_en)
		begin
			tx_st <= TX_IDLE;
			tx_os <= 4'h0;
			tx_bit <= 4'h0;
			tx_sh <= 9'h0;
			tx_line <= 1'b1;
		end
		else
		begin
			if (tick)
				tx_os <= tx_os + 4'h1;
			case (tx_st)
				TX_IDLE:
				begin
					tx_line <= 1'b1;
					tx_os <= 4'h0;
					if (tx_sbk_take)
					begin
						tx_st <= TX_BRK;
						tx_bit <= 4'h0;
						tx_line <= 1'b0;
					end
					else if (tick && tx_pend && transmitter_en)
					begin
						tx_st <= TX_START;
						tx_line <= 1'b0;
						tx_sh <= tx_word;
						if (parity_enable)
						begin
							if (wlen9)
								tx_sh[8] <= par_of(tx_word, 1'b1, parity_select);
							else
								tx_sh[7] <= par_of(tx_word, 1'b0, parity_select);
						end
					end
				end
				TX_START:
					if (tx_bit_end)
					begin
						tx_st <= TX_DATA;
						tx_bit <= 4'h0;
						tx_line <= tx_sh[0];
					end
				TX_DATA:
					if (tx_bit_end)
					begin
						tx_sh <= {1'b0, tx_sh[8:1]};
						if (tx_bit == nbits - 4'h1)
						begin
							tx_st <= TX_STOP;
							tx_line <= 1'b1;
						end
						else
						begin
							tx_bit <= tx_bit + 4'h1;
							tx_line <= tx_sh[1];
						end
					end
				TX_STOP:
					if (tx_bit_end)
						tx_st <= TX_IDLE;
				TX_BRK:
					if (tx_bit_end)
					begin
						if (tx_bit == 4'(BRK_TX_BITS - 1))
						begin
							tx_st <= TX_BRKSTOP;
							tx_bit <= 4'h0;
							tx_line <= 1'b1;
						end
						else
							tx_bit <= tx_bit + 4'h1;
					end
				TX_BRKSTOP:
					if (tx_bit_end)
					begin
						if (tx_bit == 4'(BRK_TX_STOP - 1))
							tx_st <= TX_IDLE;
						else
							tx_bit <= tx_bit + 4'h1;
					end
				default:
					tx_st <= TX_IDLE;
			endcase
		end
	end
	// data register write fills the pending word; shifter take empties it
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			tx_word <= 9'h0;
			tx_pend <= 1'b0;
		end
		else if (wr_data)
		begin
			tx_word <= avs_writedata[8:0];
			tx_pend <= 1'b1;
		end
		else if (tx_st == TX_IDLE && tx_pend && transmitter_en && peripheral_en
			&& tick && !tx_sbk_take)
			tx_pend <= 1'b0;
	end
	// pin drive: half duplex releases the wire when not sending
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			tx_out <= 1'b1;
			tx_oe <= 1'b0;
		end
		else
		begin
			tx_out <= tx_line;
			tx_oe <= half_duplex_sel ? tx_st != TX_IDLE : peripheral_en;
		end
	end
	// synchronous clock: pulses only in data bits, the last one optional
	wire logic clk_bit = sync_clock_en && tx_st == TX_DATA
		&& (tx_bit != nbits - 4'h1 || last_bit_clock_pulse);
	// phase clear: first edge mid bit; phase set: first edge at bit start
	wire logic clk_act = clock_phase ? tx_os < 4'(OVS / 2) : tx_os >= 4'(OVS / 2);
	always_ff @(posedge mclk)
	begin
		if (reset)
			sync_clk <= 1'b0;
		else
			sync_clk <= clock_polarity ^ (clk_bit && clk_act);
	end
	// receiver, asynchronous or clocked by our own synchronous clock
	ufo_rx_t rx_st;
	logic [3:0] rx_os; // oversample count
	logic [3:0] rx_bit; // bit index
	logic [8:0] rx_sh; // shift register
	logic [2:0] rx_maj; // samples 8, 9, 10
	logic bd_release; // break detector lets a halted receiver go
	wire logic maj = (rx_maj[0] & rx_maj[1]) | (rx_maj[1] & rx_maj[2])
		| (rx_maj[0] & rx_maj[2]);
	// sample point for the sync receiver: the clock edge just before mid or end of bit
	// every data bit is taken, also the last one when its pulse is suppressed
	wire logic sync_samp = sync_clock_en && tx_st == TX_DATA && tick
		&& tx_os == (clock_phase ? 4'(OVS / 2 - 1) : 4'(OVS - 1));
	wire logic rx_fin = rx_st == RX_STOP && tick && rx_os == 4'(OVS - 1);
	always_ff @(posedge mclk)
	begin
		if (reset || !peripheral_en || !receiver_en)
		begin
			rx_st <= RX_IDLE;
			rx_os <= 4'h0;
			rx_bit <= 4'h0;
			rx_sh <= 9'h0;
			rx_maj <= 3'h7;
		end
		else if (sync_clock_en)
		begin
			// no oversampling: shift one bit per data bit of the transmitted frame
			rx_st <= RX_IDLE;
			if (sync_samp)
				rx_sh <= {rx_in, rx_sh[8:1]};
		end
		else
		begin
			if (tick)
			begin
				rx_os <= rx_os + 4'h1;
				if (rx_os == 4'(MAJ_A) || rx_os == 4'(MAJ_B) || rx_os == 4'(MAJ_C))
					rx_maj <= {rx_in, rx_maj[2:1]};
			end
			case (rx_st)
				RX_IDLE:
					if (!rx_in)
					begin
						rx_st <= RX_DATA;
						rx_os <= 4'h0;
						rx_bit <= 4'h0;
					end
				RX_DATA:
					if (tick && rx_os == 4'(OVS - 1))
					begin
						// first bit period is the start bit
						if (rx_bit != 4'h0)
							rx_sh <= {maj, rx_sh[8:1]};
						if (rx_bit == nbits)
							rx_st <= RX_STOP;
						rx_bit <= rx_bit + 4'h1;
					end
				RX_STOP:
					if (rx_fin)
						rx_st <= (!maj && lin_mode_en) ? RX_HALT : RX_IDLE;
				RX_HALT:
					if (bd_release)
						rx_st <= RX_IDLE;
				default:
					rx_st <= RX_IDLE;
			endcase
		end
	end
	// word alignment: eight bit frames shift one place short
	wire logic [8:0] rx_got = wlen9 ? rx_sh : {1'b0, rx_sh[8:1]};
	// clocked frames store one cycle after the last data bit ends, so a shift on the
	// final bit-end tick is not lost
	logic sync_last; // last data bit of a clocked frame has just ended
	always_ff @(posedge mclk)
	begin
		if (reset)
			sync_last <= 1'b0;
		else
			sync_last <= sync_clock_en && tx_st == TX_DATA && tx_bit_end
				&& tx_bit == nbits - 4'h1;
	end
	wire logic rx_done = rx_fin || (sync_last && receiver_en);
	wire logic rx_perr = parity_enable
		&& (wlen9 ? rx_got[8] : rx_got[7]) != par_of(rx_got, wlen9, parity_select);
	// received word, parity bit stays in the msb position
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			rx_word <= 9'h0;
			rxne <= 1'b0;
		end
		else if (rx_done)
		begin
			rx_word <= rx_got;
			rxne <= 1'b1;
		end
		else if (rd && avs_address == ADDR_DATA)
			rxne <= 1'b0;
	end
	// break detector with its own bit timing, independent of the receiver
	ufo_bd_t bd_st;
	logic [3:0] bd_os; // oversample count
	logic [3:0] bd_zeros; // consecutive zero bits
	logic [2:0] bd_maj; // samples 8, 9, 10
	logic bd_set; // break found
	wire logic bd_bit = (bd_maj[0] & bd_maj[1]) | (bd_maj[1] & bd_maj[2])
		| (bd_maj[0] & bd_maj[2]);
	wire logic [3:0] bd_need = break_len_sel ? 4'(BRK_RX_LONG) : 4'(BRK_RX_SHORT);
	always_ff @(posedge mclk)
	begin
		if (reset || !lin_mode_en || !receiver_en || !peripheral_en)
		begin
			bd_st <= BD_SEEK;
			bd_os <= 4'h0;
			bd_zeros <= 4'h0;
			bd_maj <= 3'h7;
			bd_set <= 1'b0;
			bd_release <= 1'b0;
		end
		else
		begin
			bd_set <= 1'b0;
			bd_release <= 1'b0;
			if (tick)
			begin
				bd_os <= bd_os + 4'h1;
				if (bd_os == 4'(MAJ_A) || bd_os == 4'(MAJ_B) || bd_os == 4'(MAJ_C))
					bd_maj <= {rx_in, bd_maj[2:1]};
			end
			case (bd_st)
				BD_SEEK:
					if (!rx_in)
					begin
						bd_st <= BD_COUNT;
						bd_os <= 4'h0;
						bd_zeros <= 4'h0;
					end
				BD_COUNT:
					if (tick && bd_os == 4'(OVS - 1))
					begin
						if (bd_bit)
						begin
							bd_st <= BD_SEEK;
							bd_release <= 1'b1;
						end
						else if (bd_zeros + 4'h1 == bd_need)
							bd_st <= BD_DELIM;
						else
							bd_zeros <= bd_zeros + 4'h1;
					end
				BD_DELIM:
					if (rx_in)
					begin
						bd_st <= BD_SEEK;
						bd_set <= 1'b1;
						bd_release <= 1'b1;
					end
				default:
					bd_st <= BD_SEEK;
			endcase
		end
	end
	// sticky flags: a set in the same cycle as a clear wins
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			parity_error_flag <= 1'b0;
			break_detected_flag <= 1'b0;
			ferr <= 1'b0;
		end
		else
		begin
			if (rx_done && rx_perr)
				parity_error_flag <= 1'b1;
			else if (wr_clr && avs_writedata[K_PERR])
				parity_error_flag <= 1'b0;
			if (bd_set)
				break_detected_flag <= 1'b1;
			else if (wr_clr && avs_writedata[K_BRK])
				break_detected_flag <= 1'b0;
			if (rx_fin && !maj)
				ferr <= 1'b1;
			else if (wr_clr && avs_writedata[K_FERR])
				ferr <= 1'b0;
		end
	end
	// interrupt request, level, gated by the enables
	always_ff @(posedge mclk)
	begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= (parity_error_flag && ctrl[C_PARIE])
				|| (break_detected_flag && ctrl[C_BRKIE]);
	end
endmodule : ufo_frame

// ---- tb/ufo_frame_properties.sv ----
// port-level checker for the frame option block
`timescale 1ns/100ps
module ufo_frame_properties
	import ufo_pkg::*;
#(
	parameter int DIV_W = 16
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic rx_pin,
	input wire logic tx_out,
	input wire logic tx_oe,
	input wire logic sync_clk,
	input wire logic irq
);
	logic [31:0] ctrl_q; // shadow of the control word, taken from bus writes
	logic [31:0] lo_n; // consecutive low cycles on tx
	logic [31:0] hi_n; // consecutive high cycles on tx
	logic brk_seen; // last low run on tx was a full break
	logic req; // any bus request
	logic [31:0] bit_n; // mclk cycles per bit
	logic cfg_still; // control word unchanged for two cycles
	assign req = avs_read | avs_write;
	assign bit_n = {12'h0, ctrl_q[31:16], 4'h0};
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	// shadow follows only accepted writes, so it matches what the block took
	always_ff @(posedge mclk)
	begin
		if (reset)
			ctrl_q <= 32'h0010_0000;
		else if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL)
			ctrl_q <= avs_writedata;
	end
	// run lengths on the transmit line
	always_ff @(posedge mclk)
	begin
		lo_n <= (reset || tx_out) ? 32'h0 : lo_n + 32'h1;
		hi_n <= (reset || !tx_out) ? 32'h0 : hi_n + 32'h1;
	end
	// remember a break until the next falling edge
	always_ff @(posedge mclk)
	begin
		if (reset || !tx_out)
			brk_seen <= 1'b0;
		else if (lo_n == bit_n * BRK_TX_BITS)
			brk_seen <= 1'b1;
	end
	always_ff @(posedge mclk)
	begin
		cfg_still <= !reset && avs_address != ADDR_CTRL || !avs_write || avs_waitrequest;
	end
	a_wait_one_cycle: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest not low one cycle after request");
	a_wait_needs_req: assert property (!avs_waitrequest |-> req)
		else $error("waitrequest low without request");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00
		|-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_oe_normal: assert property (!ctrl_q[C_HDX] && $stable(ctrl_q) && cfg_still
		|-> tx_oe == ctrl_q[C_PERIPH])
		else $error("tx enable differs from peripheral enable");
	a_hdx_low_driven: assert property (ctrl_q[C_HDX] && !tx_out |-> tx_oe)
		else $error("half duplex low level not driven");
	a_break_length: assert property ($rose(tx_out) && lo_n > bit_n * 10
		|-> lo_n == bit_n * BRK_TX_BITS)
		else $error("break low time wrong");
	a_break_tail: assert property ($fell(tx_out) && brk_seen
		|-> hi_n >= bit_n * BRK_TX_STOP)
		else $error("break tail too short");
	a_sync_idle_level: assert property (ctrl_q[C_SYNC] && hi_n > bit_n * 12 && $stable(ctrl_q)
		&& cfg_still |-> sync_clk == ctrl_q[C_CLOCK_POLARITY])
		else $error("sync clock idle level wrong");
	a_irq_needs_en: assert property (!ctrl_q[C_PARIE] && !ctrl_q[C_BRKIE] && $stable(ctrl_q)
		|-> !irq)
		else $error("irq without enable");
endmodule : ufo_frame_properties

// ---- tb/ufo_remote_node.sv ----
// remote serial node driving the receive line with a bit burst
`timescale 1ns/100ps
module ufo_remote_node
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [15:0] bit_cyc,
	input wire logic go,
	input wire logic [15:0] pat,
	input wire logic [4:0] nbits,
	output logic line,
	output logic busy
);
	logic [15:0] sh; // bits still to send, lsb next
	logic [4:0] left; // bits left in the burst
	logic [15:0] cnt; // cycles into the current bit
	// line idles high as the pull-up holds it; bursts go lsb first
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			line <= 1'b1;
			busy <= 1'b0;
		end
		else if (go && !busy)
		begin
			sh <= pat;
			left <= nbits;
			cnt <= 16'h0;
			busy <= 1'b1;
			line <= pat[0];
		end
		else if (busy && cnt == bit_cyc - 16'h1)
		begin
			cnt <= 16'h0;
			left <= left - 5'h1;
			sh <= sh >> 1;
			busy <= left != 5'h1;
			line <= (left == 5'h1) | sh[1];
		end
		else if (busy)
			cnt <= cnt + 16'h1;
	end
endmodule : ufo_remote_node

// ---- tb/tb_top.sv ----
// top bench of the frame option block against a remote serial node
`timescale 1ns/100ps
module tb_top;
	import ufo_pkg::*;
	localparam logic [15:0] DIV = 16'h0002; // short bit time keeps the run quick
	localparam logic [15:0] BT = 16'h0020; // mclk cycles per bit at that divider
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, rx_pin, tx_out, tx_oe, sync_clk, irq;
	logic node_go = 1'b0;
	logic [15:0] node_pat = 16'h0;
	logic [4:0] node_n = 5'h0;
	logic node_busy;
	logic [31:0] rd; // last read word
	int miscompares = 0;
	int n_tests = 0;
	always #12.5 mclk = ~mclk;
	ufo_frame #(.DIV_W(16)) ufo_frame_i (.mclk(mclk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin),
		.tx_out(tx_out), .tx_oe(tx_oe), .sync_clk(sync_clk), .irq(irq));
	ufo_remote_node ufo_remote_node_i (.mclk(mclk), .reset(reset), .bit_cyc(BT), .go(node_go),
		.pat(node_pat), .nbits(node_n), .line(rx_pin), .busy(node_busy));
	task automatic conclude();
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
		begin
			@(posedge mclk);
			n++;
		end
		chk(n, 32'h1);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	// sample a transmitted frame mid-bit, lsb first
	task automatic cap_tx(input int n, output logic [8:0] w);
		int k;
		w = 9'h0;
		for (k = 0; tx_out !== 1'b0 && k < 2000; k++)
			@(posedge mclk);
		repeat (BT / 2) @(posedge mclk);
		chk({31'h0, tx_oe}, 32'h1);
		for (k = 0; k < n; k++)
		begin
			repeat (BT) @(posedge mclk);
			w[k] = tx_out;
		end
		repeat (BT) @(posedge mclk);
		chk({31'h0, tx_out}, 32'h1);
		repeat (BT) @(posedge mclk);
	endtask : cap_tx
	task automatic send(input logic [15:0] p, input int n);
		node_pat <= p;
		node_n <= 5'(n);
		node_go <= 1'b1;
		@(posedge mclk);
		node_go <= 1'b0;
		@(posedge mclk);
		while (node_busy)
			@(posedge mclk);
		repeat (2 * BT) @(posedge mclk);
	endtask : send
	initial
	begin
		logic [8:0] w, e;
		logic [31:0] c;
		logic p, prev;
		int i, nb;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		rdc(ADDR_CTRL, 32'h0010_0000);
		rdc(ADDR_STAT, 32'h0);
		rdc(4'h2, 32'h0);
		// every frame format and parity sense on transmit
		for (i = 0; i < 8; i++)
		begin
			c = {DIV, 16'h0007} | 32'(i[0]) << C_WLEN9 | 32'(i[1]) << C_PAREN | 32'(i[2]) << C_PARSEL;
			wr(ADDR_CTRL, c);
			wr(ADDR_DATA, 32'h135);
			nb = i[0] ? 9 : 8;
			e = i[0] ? 9'h135 : 9'h035;
			p = (i[0] ? ^e[7:0] : ^e[6:0]) ^ i[2];
			if (i[1])
				e[nb - 1] = p;
			cap_tx(nb, w);
			chk({23'h0, w}, {23'h0, e});
		end
		// receive good, bad with irq enabled, bad with irq masked
		for (i = 0; i < 3; i++)
		begin
			wr(ADDR_CTRL, {DIV, 16'h0017} | 32'(i < 2) << C_PARIE);
			p = i > 0;
			send({6'h3f, 1'b1, p, 7'h35, 1'b0}, 10);
			rdc(ADDR_STAT, {26'h0, 1'(i == 1), 3'b001, 1'b0, p});
			chk({31'h0, irq}, 32'(i == 1));
			rdc(ADDR_DATA, {24'h0, p, 7'h35});
			wr(ADDR_CLR, 32'h1);
			rdc(ADDR_STAT, 32'h0);
		end
		// break on transmit: thirteen low bits then two high
		wr(ADDR_CTRL, {DIV, 16'h0083});
		wr(ADDR_CTRL, {DIV, 16'h8083});
		for (nb = 0; tx_out !== 1'b0 && nb < 500; nb++)
			@(posedge mclk);
		for (nb = 0; tx_out === 1'b0 && nb < 1000; nb++)
			@(posedge mclk);
		chk(nb, 13 * BT);
		for (nb = 0; tx_out === 1'b1 && nb < 2 * BT; nb++)
			@(posedge mclk);
		chk(nb, 2 * BT);
		// break detect: short and long per length, then with the mode off
		for (i = 0; i < 5; i++)
		begin
			nb = i == 4 ? 14 : 8 + 4 * i[0] + i[1];
			wr(ADDR_CTRL, {DIV, 16'h0207} | 32'(!i[2]) << C_LIN | 32'(i[1]) << C_BRKLEN);
			send(16'hffff << nb, nb + 1);
			bus(1'b0, ADDR_STAT, 32'h0);
			chk(rd & 32'h22, {26'h0, i[0], 3'h0, i[0], 1'b0});
			chk({31'h0, irq}, {31'h0, i[0]});
			wr(ADDR_CLR, 32'h13);
		end
		// synchronous clock for each last-bit, polarity and phase choice
		for (i = 0; i < 8; i++)
		begin
			c = {DIV, 16'h0406} | 32'(i) << C_LAST_BIT_CLOCK_PULSE;
			wr(ADDR_CTRL, {DIV, 16'h0000});
			wr(ADDR_CTRL, c);
			wr(ADDR_CTRL, c | 32'h1);
			repeat (2) @(posedge mclk);
			chk({31'h0, sync_clk}, {31'h0, i[1]});
			wr(ADDR_DATA, 32'ha5);
			nb = 0;
			prev = sync_clk;
			repeat (11 * BT)
			begin
				@(posedge mclk);
				nb += int'(sync_clk !== prev && prev === i[1]);
				prev = sync_clk;
			end
			chk(nb, i[0] ? 8 : 7);
			rdc(ADDR_DATA, 32'hff);
		end
		// half duplex releases the line outside frames
		wr(ADDR_CTRL, {DIV, 16'h4003});
		repeat (2) @(posedge mclk);
		chk({31'h0, tx_oe}, 32'h0);
		wr(ADDR_DATA, 32'h5a);
		cap_tx(8, w);
		chk({23'h0, w}, 32'h5a);
		chk({31'h0, tx_oe}, 32'h0);
		conclude();
	end
	// hang guard, well beyond the expected run length
	initial
	begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		conclude();
	end
endmodule : tb_top
bind ufo_frame ufo_frame_properties #(.DIV_W(DIV_W)) ufo_frame_properties_i (.mclk(mclk),
	.reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .tx_out(tx_out), .tx_oe(tx_oe),
	.sync_clk(sync_clk), .irq(irq));
